// File: bpc_palette_mem.sv
// Colour table storage with one write port and one registered read port.
module bpc_palette_mem #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 12,
    parameter int AW = 5
) (
    input wire logic clk_sys,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_r
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Old contents are read when a write hits the same entry, so a pixel in flight is not disturbed.
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_r <= mem[rdAddr];
    end

endmodule

// File: bpc_pkg.sv
// Package with register map, field layout, playfield dimensions and carrier types of the playfield colour block.
package bpc_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [11:0] BPC_OFF_PLANE_CTRL = 12'h000;
    localparam logic [11:0] BPC_OFF_MODE_CTRL = 12'h004;
    localparam logic [11:0] BPC_OFF_STATUS = 12'h008;
    localparam logic [11:0] BPC_OFF_PALETTE = 12'h080;
    localparam logic [11:0] BPC_PALETTE_SPAN = 12'h080;

    // -----------------------------------------------------------------
    // Field layout and reset values
    // -----------------------------------------------------------------
    localparam int BPC_CW_FINE_HORIZ = 15;
    localparam int BPC_CW_COUNT_MSB = 14;
    localparam int BPC_CW_COUNT_LSB = 12;
    localparam int BPC_CW_INTERLEAVED = 2;
    localparam int BPC_MODE_OVERLAY = 0;
    localparam int BPC_MODE_DUAL = 1;
    localparam int BPC_MODE_HOLD = 2;
    localparam logic [15:0] BPC_PLANE_CTRL_RESET = 16'h0000;
    localparam logic [2:0] BPC_MODE_RESET = 3'h0;
    localparam logic [2:0] BPC_COUNT_UNUSED = 3'h7;
    localparam logic [2:0] BPC_COUNT_FINE_HORIZONTAL_SELECT_MAX = 3'h4;

    // -----------------------------------------------------------------
    // Playfield dimensions
    // -----------------------------------------------------------------
    localparam logic [9:0] BPC_WIDTH_LORES = 10'd320;
    localparam logic [9:0] BPC_WIDTH_FINE_HORIZONTAL_SELECT = 10'd640;
    localparam logic [9:0] BPC_HEIGHT_60HZ = 10'd200;
    localparam logic [9:0] BPC_HEIGHT_50HZ = 10'd256;

    // -----------------------------------------------------------------
    // Carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic inWindow;
        logic objPresent;
        logic [4:0] objIndex;
        logic [5:0] planeBits;
    } bpc_pixel_t;

    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } bpc_rgb_t;

endpackage

// File: bpc_top.sv
// Playfield colour logic: plane control word, colour table and pixel colour lookup on AHB-Lite.
//
// Functional notes
// - Colour table holds 32 writable entries of 12 bits each.
// - Entry word: red bits 11-8, green 7-4, blue 3-0; bits 15-12 ignored.
// - Colour entries are write-only; reads return zero, software keeps shadow copies.
// - Entry zero shows where no pixel is present and outside the window.
// - With overlay enabled, external video replaces every background pixel.
// - Plane count field sits in control word bits 14 down to 12.
// - Counts 1 to 5 enable planes 1 to n consecutively.
// - Count zero fetches no planes and shows only the background and object pixels.
// - Count six enables six planes; sixth only used in dual or hold modes.
// - Control word is only written whole; no per-bit set or clear.
// - Writing 2200 hex selects two low-resolution planes with all options off.
// - Full playfield width is 320 in low and 640 in high resolution.
// - Height 200/400 interlaced at 60 Hz, 256/512 interlaced at 50 Hz.
// - Highest-numbered active plane gives the most significant index bit.
// - Control word bit 15 selects high horizontal resolution.
// - Control word bit 2 selects interlaced scanning.
// - High resolution allows at most four planes.
module bpc_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_r,
    output logic hreadyout_r,
    output logic hresp_r,
    input wire logic palStandard,
    input wire bpc_pkg::bpc_pixel_t pixelIn,
    input wire bpc_pkg::bpc_rgb_t extVideo,
    output bpc_pkg::bpc_rgb_t pixelRgb_r,
    output logic pixelValid_r,
    output logic pixelIsExternal_r,
    output logic sixthPlaneBit_r,
    output logic [5:0] planeFetchEn_r,
    output logic [15:0] planeControl_r,
    output logic [9:0] playfieldWidth_r,
    output logic [9:0] playfieldHeight_r
);

    // -----------------------------------------------------------------
    // Bus slave: address phase capture and decode
    // -----------------------------------------------------------------
    logic wrPend_r;
    logic [11:0] wrAddr_r;
    logic [2:0] modeCtrl_r;
    logic [2:0] modeCtrl_nxt;
    logic [15:0] planeControl_nxt;
    logic [31:0] hrdata_nxt;

    wire addrPhase = hsel & htrans[1] & hready;
    wire rdStart = addrPhase & ~hwrite;
    wire wrStart = addrPhase & hwrite;
    wire hitPlaneWr = wrPend_r & (wrAddr_r == bpc_pkg::BPC_OFF_PLANE_CTRL);
    wire hitModeWr = wrPend_r & (wrAddr_r == bpc_pkg::BPC_OFF_MODE_CTRL);
    wire hitPaletteWr = wrPend_r & (wrAddr_r[11:7] == bpc_pkg::BPC_OFF_PALETTE[11:7]);
    wire rdStatus = haddr == bpc_pkg::BPC_OFF_STATUS;
    wire rdMode = haddr == bpc_pkg::BPC_OFF_MODE_CTRL;

    // The whole word replaces the control register; there is no bit-level update path.
    assign planeControl_nxt = hitPlaneWr ? hwdata[15:0] : planeControl_r;
    assign modeCtrl_nxt = hitModeWr ? hwdata[2:0] : modeCtrl_r;

    // Latch the write address so the data phase can commit it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 12'h000;
        end else begin
            wrPend_r <= wrStart;
            wrAddr_r <= wrStart ? haddr : wrAddr_r;
        end
    end

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            planeControl_r <= bpc_pkg::BPC_PLANE_CTRL_RESET;
            modeCtrl_r <= bpc_pkg::BPC_MODE_RESET;
        end else begin
            planeControl_r <= planeControl_nxt;
            modeCtrl_r <= modeCtrl_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Decoded display mode
    // -----------------------------------------------------------------
    wire [2:0] countField = planeControl_r[bpc_pkg::BPC_CW_COUNT_MSB:bpc_pkg::BPC_CW_COUNT_LSB];
    wire fineHorizontalSelect = planeControl_r[bpc_pkg::BPC_CW_FINE_HORIZ];
    wire interleavedFieldSelect = planeControl_r[bpc_pkg::BPC_CW_INTERLEAVED];
    wire overlayEn = modeCtrl_r[bpc_pkg::BPC_MODE_OVERLAY];
    wire sixthAllowed = modeCtrl_r[bpc_pkg::BPC_MODE_DUAL] | modeCtrl_r[bpc_pkg::BPC_MODE_HOLD];
    wire countUnused = countField == bpc_pkg::BPC_COUNT_UNUSED;
    wire hiresCap = fineHorizontalSelect & (countField > bpc_pkg::BPC_COUNT_FINE_HORIZONTAL_SELECT_MAX);
    wire [2:0] planeCount;
    wire [6:0] maskWide;
    wire [5:0] planeMask;

    // The unused code fetches nothing; high resolution caps the count at four.
    assign planeCount = countUnused ? 3'h0 : (hiresCap ? bpc_pkg::BPC_COUNT_FINE_HORIZONTAL_SELECT_MAX : countField);
    // Planes 1..n are enabled consecutively; a count of zero enables none.
    assign maskWide = (7'h01 << planeCount) - 7'h01;
    assign planeMask = maskWide[5:0];

    // Playfield dimensions follow the resolution, scan mode and video standard.
    wire [9:0] baseWidth = fineHorizontalSelect ? bpc_pkg::BPC_WIDTH_FINE_HORIZONTAL_SELECT : bpc_pkg::BPC_WIDTH_LORES;
    wire [9:0] baseHeight = palStandard ? bpc_pkg::BPC_HEIGHT_50HZ : bpc_pkg::BPC_HEIGHT_60HZ;
    wire [9:0] fullHeight = interleavedFieldSelect ? {baseHeight[8:0], 1'b0} : baseHeight;

    // Mode outputs are registered copies of the decoded control state.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            planeFetchEn_r <= 6'h00;
            playfieldWidth_r <= bpc_pkg::BPC_WIDTH_LORES;
            playfieldHeight_r <= bpc_pkg::BPC_HEIGHT_60HZ;
        end else begin
            planeFetchEn_r <= planeMask;
            playfieldWidth_r <= baseWidth;
            playfieldHeight_r <= fullHeight;
        end
    end

    // -----------------------------------------------------------------
    // Bus slave: read data and response
    // -----------------------------------------------------------------
    wire [31:0] statusWord = {26'h0000000, interleavedFieldSelect, fineHorizontalSelect, 1'b0, planeCount};

    // Only mode and status read back; control word and colour entries read as zero.
    assign hrdata_nxt = rdStatus ? statusWord : (rdMode ? {29'h00000000, modeCtrl_r} : 32'h00000000);

    // Zero-wait slave: every transfer completes in one data phase with OKAY.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hrdata_r <= rdStart ? hrdata_nxt : 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Pixel index formation
    // -----------------------------------------------------------------
    wire [4:0] playfieldIndex;
    wire sixthBit;
    wire bgPixel;
    wire [4:0] lookupIndex;

    // Plane 1 is bit 0 and plane 5 bit 4; disabled planes are forced to zero.
    assign playfieldIndex = pixelIn.planeBits[4:0] & planeMask[4:0];
    // The sixth plane only counts in dual-playfield or hold-and-modify modes.
    assign sixthBit = pixelIn.planeBits[5] & planeMask[5] & sixthAllowed;
    // Background wherever nothing is drawn and everywhere in the border.
    assign bgPixel = ~pixelIn.inWindow | (~pixelIn.objPresent & (playfieldIndex == 5'h00) & ~sixthBit);
    assign lookupIndex = ~pixelIn.inWindow ? 5'h00 : (pixelIn.objPresent ? pixelIn.objIndex : playfieldIndex);

    // -----------------------------------------------------------------
    // Colour table
    // -----------------------------------------------------------------
    logic [11:0] entryColour;

    // Writes land at the end of the data phase; the upper four bits of the word are dropped.
    bpc_palette_mem #(
        .DEPTH(32),
        .WIDTH(12),
        .AW(5)
    ) u_palette (
        .clk_sys(clk_sys),
        .wrEn(hitPaletteWr),
        .wrAddr(wrAddr_r[6:2]),
        .wrData(hwdata[11:0]),
        .rdAddr(lookupIndex),
        .rdData_r(entryColour)
    );

    // -----------------------------------------------------------------
    // Pixel pipeline
    // -----------------------------------------------------------------
    logic s1Valid_r;
    logic s1Bg_r;
    logic s1Sixth_r;
    bpc_pkg::bpc_rgb_t s1Ext_r;
    bpc_pkg::bpc_rgb_t colourOut;
    wire useExternal = overlayEn & s1Bg_r;

    // Red, green and blue nibbles are split from the stored entry.
    assign colourOut = useExternal ? s1Ext_r : bpc_pkg::bpc_rgb_t'(entryColour);

    // Stage one travels alongside the colour table read.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1Valid_r <= 1'b0;
            s1Bg_r <= 1'b0;
            s1Sixth_r <= 1'b0;
            s1Ext_r <= '0;
        end else begin
            s1Valid_r <= pixelIn.valid;
            s1Bg_r <= bgPixel;
            s1Sixth_r <= sixthBit;
            s1Ext_r <= extVideo;
        end
    end

    // Stage two drives the final colour and its tags.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pixelRgb_r <= '0;
            pixelValid_r <= 1'b0;
            pixelIsExternal_r <= 1'b0;
            sixthPlaneBit_r <= 1'b0;
        end else begin
            pixelRgb_r <= colourOut;
            pixelValid_r <= s1Valid_r;
            pixelIsExternal_r <= useExternal;
            sixthPlaneBit_r <= s1Sixth_r;
        end
    end

endmodule

// File: bpc_top_properties.sv
// Checker holding the port-level properties of the playfield colour block.
module bpc_top_properties (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata_r,
    input wire logic palStandard,
    input wire bpc_pkg::bpc_pixel_t pixelIn,
    input wire bpc_pkg::bpc_rgb_t extVideo,
    input wire bpc_pkg::bpc_rgb_t pixelRgb_r,
    input wire logic pixelValid_r,
    input wire logic pixelIsExternal_r,
    input wire logic sixthPlaneBit_r,
    input wire logic [5:0] planeFetchEn_r,
    input wire logic [15:0] planeControl_r,
    input wire logic [9:0] playfieldWidth_r,
    input wire logic [9:0] playfieldHeight_r
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    logic [2:0] effCount;
    // Unused count code means no planes; high resolution caps the count at four.
    assign effCount = (planeControl_r[14:12] == 3'h7) ? 3'h0 :
        ((planeControl_r[15] && planeControl_r[14:12] > 3'h4) ? 3'h4 : planeControl_r[14:12]);
    // Word and standard held two cycles, so every derived output has caught up.
    sequence ctrl_settled;
        $stable(planeControl_r) && $stable(palStandard) ##1 $stable(planeControl_r) && $stable(palStandard);
    endsequence
    table_read_a: assert property (hsel && htrans[1] && hready && !hwrite && (haddr == 12'h000 || haddr >= 12'h080)
        |=> hrdata_r == 32'h0) else $error("write-only register returned data");
    fetch_mask_a: assert property (ctrl_settled |->
        planeFetchEn_r == 6'((7'h1 << effCount) - 7'h1)) else $error("plane fetch mask wrong");
    width_a: assert property (ctrl_settled |-> playfieldWidth_r == (planeControl_r[15] ? 10'h280 : 10'h140))
        else $error("playfield width wrong");
    height_a: assert property (ctrl_settled |->
        playfieldHeight_r == ((palStandard ? 10'h100 : 10'h0c8) << planeControl_r[2])) else $error("height wrong");
    pixel_delay_a: assert property (pixelValid_r == $past(pixelIn.valid, 2)) else $error("pixel latency wrong");
    ext_video_a: assert property (pixelIsExternal_r |-> pixelRgb_r == $past(extVideo, 2))
        else $error("overlay pixel not from external video");
    object_shown_a: assert property (pixelIn.valid && pixelIn.inWindow && pixelIn.objPresent |-> ##2 !pixelIsExternal_r)
        else $error("object pixel replaced by overlay");
    sixth_plane_a: assert property (sixthPlaneBit_r |-> $past(planeControl_r[14:12], 2) == 3'h6)
        else $error("sixth plane bit without six planes");
endmodule

bind bpc_top bpc_top_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata_r(hrdata_r), .palStandard(palStandard),
    .pixelIn(pixelIn), .extVideo(extVideo), .pixelRgb_r(pixelRgb_r), .pixelValid_r(pixelValid_r),
    .pixelIsExternal_r(pixelIsExternal_r), .sixthPlaneBit_r(sixthPlaneBit_r), .planeFetchEn_r(planeFetchEn_r),
    .planeControl_r(planeControl_r), .playfieldWidth_r(playfieldWidth_r), .playfieldHeight_r(playfieldHeight_r));

// File: testbench.sv
// Self-checking testbench of the playfield colour block against a behavioural model.
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value %0t %s", $time, m); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_b, hsel, hwrite, palStandard, hreadyout_r, hresp_r, pixelValid_r, pixelIsExternal_r;
    logic sixthPlaneBit_r;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata_r;
    bpc_pkg::bpc_pixel_t pixelIn;
    bpc_pkg::bpc_rgb_t extVideo, pixelRgb_r;
    logic [5:0] planeFetchEn_r;
    logic [15:0] planeControl_r;
    logic [9:0] playfieldWidth_r, playfieldHeight_r;
    int n_fail = 0, tests_run = 0, seed = 18, ctrlW = 0, modeW = 0;
    int pal[32];
    bpc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_r), .hrdata_r(hrdata_r),
        .hreadyout_r(hreadyout_r), .hresp_r(hresp_r), .palStandard(palStandard), .pixelIn(pixelIn),
        .extVideo(extVideo), .pixelRgb_r(pixelRgb_r), .pixelValid_r(pixelValid_r),
        .pixelIsExternal_r(pixelIsExternal_r), .sixthPlaneBit_r(sixthPlaneBit_r), .planeFetchEn_r(planeFetchEn_r),
        .planeControl_r(planeControl_r), .playfieldWidth_r(playfieldWidth_r), .playfieldHeight_r(playfieldHeight_r));
    // Clock at 10 MHz and a watchdog that ends a hung run.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Bus master and reference model
    // ------------------------------------------------------------
    task automatic waitReady();
        int t;
        t = 0;
        @(posedge clk_sys);
        while (hreadyout_r !== 1'b1 && t < 50) begin
            @(posedge clk_sys);
            t++;
        end
    endtask
    // One single transfer: address phase, then data phase; read data taken at its last edge.
    // The transfer starts at a rising edge so every bus signal changes right after it.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        hwrite <= wr;
        haddr <= a;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        waitReady();
        q = hrdata_r;
        `CHK(hreadyout_r, 1'b1, "ready")
        `CHK(hresp_r, 1'b0, "response")
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e, m)
    endtask
    function automatic int effCnt(int w);
        int c;
        c = (w >> 12) & 7;
        if (c == 7) c = 0;
        return (((w >> 15) & 1) && c > 4) ? 4 : c;
    endfunction
    // Expected output: sixth plane bit, overlay flag and colour for one pixel.
    function automatic logic [13:0] expPix(bpc_pkg::bpc_pixel_t p, bpc_pkg::bpc_rgb_t e);
        int idx;
        logic sx;
        idx = p.inWindow ? (p.objPresent ? p.objIndex : (p.planeBits[4:0] & ((1 << effCnt(ctrlW)) - 1))) : 0;
        sx = p.planeBits[5] && effCnt(ctrlW) == 6 && (modeW & 6) != 0;
        if ((modeW & 1) && (!p.inWindow || (!p.objPresent && idx == 0 && !sx))) return {sx, 1'b1, e};
        return {sx, 1'b0, pal[idx][11:0]};
    endfunction
    // Streams random pixels back to back and compares each result two edges later.
    task automatic runPix(input int n);
        logic [14:0] q[$];
        logic [14:0] x;
        bpc_pkg::bpc_pixel_t p;
        bpc_pkg::bpc_rgb_t e;
        for (int i = 0; i < n + 2; i++) begin
            @(posedge clk_sys);
            p = 14'($random(seed));
            p.valid = i < n;
            e = 12'($random(seed));
            pixelIn <= p;
            extVideo <= e;
            q.push_back({p.valid, expPix(p, e)});
            #1;
            if (q.size() == 3) begin
                x = q.pop_front();
                `CHK(pixelValid_r, x[14], "pixel valid")
                if (x[14]) begin
                    `CHK(sixthPlaneBit_r, x[13], "sixth plane bit")
                    `CHK(pixelIsExternal_r, x[12], "overlay flag")
                    `CHK(pixelRgb_r, x[11:0], "pixel colour")
                end
            end
        end
    endtask
    task automatic ctrlCase(input logic [15:0] w);
        int c;
        wr(12'h000, {16'h0, w});
        palStandard <= 1'($random(seed));
        ctrlW = w;
        c = effCnt(w);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(playfieldWidth_r, w[15] ? 10'h280 : 10'h140, "width")
        `CHK(playfieldHeight_r, (palStandard ? 10'h100 : 10'h0c8) << w[2], "height")
        `CHK(planeFetchEn_r, 6'((1 << c) - 1), "fetch mask")
        `CHK(planeControl_r, w, "control word")
        rdChk(12'h008, {26'h0, w[2], w[15], 1'b0, 3'(c)}, "status");
        runPix(24);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {hsel, hwrite, palStandard, haddr, htrans, hsize, hwdata, pixelIn, extVideo} = '0;
        rst_b = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        `CHK(planeControl_r, 16'h0000, "control reset")
        `CHK(playfieldHeight_r, 10'h0c8, "height reset")
        for (int i = 0; i < 32; i++) begin
            pal[i] = $random(seed);
            wr(12'h080 + 12'(4 * i), 32'(pal[i]));
        end
        rdChk(12'h0fc, 32'h0, "colour read");
        rdChk(12'h000, 32'h0, "control read");
        rdChk(12'h200, 32'h0, "unmapped read");
        $display("test colour table done");
        ctrlCase(16'h2200);
        ctrlCase(16'ha204);
        // Plane counts 0 to 6 only, in both resolutions; the unused code is never written.
        for (int k = 0; k < 14; k++) begin
            ctrlCase({k[0], 3'(k >> 1), 9'h0, k[1], 2'h0});
        end
        $display("test plane control done");
        wr(12'h004, 32'h1);
        modeW = 1;
        rdChk(12'h004, 32'h1, "mode read");
        wr(12'h080, 32'hf0a5c);
        pal[0] = 32'ha5c;
        ctrlCase(16'h3000);
        wr(12'h004, 32'h2);
        modeW = 2;
        ctrlCase(16'h6000);
        $display("test overlay and dual done");
        stop_test();
    end
endmodule
